//--- pgt_mask_bank.sv
/*
  Power-good tree mask bank for status outputs one and four: four byte
  registers on a plain strobe port, and the registered tree results.
  Assumes all inputs are synchronous to clk_i; read data one cycle late.
*/
// The strobed register port was left to the implementer.
// Summary of operation
// R01: Output one mask B bits 7..4 mask control inputs five, four, two, one.
// R02: Output one mask B bit 3 masks the termination regulator.
// R03: Mask B bits 2..0: shared switch/regulator source, switch B1, regulator A3.
// R04: Output four mask A at A6h: regulator A2, switch A1, buck six..one.
// R05: Output four mask B at A7h has output one mask B layout.
// R06: Mask bit 1 ignores a source; 0 keeps it in the tree.
// R07: Each mask register is eight read/write bits; reset value is variant-specific.
// R08: Output one mask A at A4h: regulator A2, switch A1, buck six..one.
// R09: Output good only while all unmasked sources good; all masked means good.
module pgt_mask_bank (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       clk_en_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // Power-good sources, high is good
  input  wire logic [5:0] buck_channel_good_i,
  input  wire logic       switch_a_one_good_i,
  input  wire logic       linear_reg_a_two_good_i,
  input  wire logic       linear_reg_a_three_good_i,
  input  wire logic       switch_b_one_good_i,
  input  wire logic       shared_source_good_i,
  input  wire logic       termination_regulator_good_i,
  // Control input pin states, bit n-1 is control input n
  input  wire logic [5:0] control_input_i,
  // Status outputs
  output logic            status_output_one_o,
  output logic            status_output_four_o
);
  logic [7:0]  mask_regs [pgt_pkg::NUM_REGS];
  logic [15:0] src_vec;
  logic [15:0] next_good_1_mask;
  logic [15:0] next_good_4_mask;
  logic        tree_good_one;
  logic        tree_good_four;

  function automatic logic [2:0] decode_addr(input logic [7:0] addr);
    case (addr)
      pgt_pkg::ADDR_OUT1_MASK_A: decode_addr = 3'h4;
      pgt_pkg::ADDR_OUT1_MASK_B: decode_addr = 3'h5;
      pgt_pkg::ADDR_OUT4_MASK_A: decode_addr = 3'h6;
      pgt_pkg::ADDR_OUT4_MASK_B: decode_addr = 3'h7;
      default:                   decode_addr = 3'h0;
    endcase
  endfunction

  function automatic logic [7:0] reset_value(input int idx);
    case (idx)
      0:       reset_value = pgt_pkg::RST_OUT1_MASK_A;
      1:       reset_value = pgt_pkg::RST_OUT1_MASK_B;
      2:       reset_value = pgt_pkg::RST_OUT4_MASK_A;
      default: reset_value = pgt_pkg::RST_OUT4_MASK_B;
    endcase
  endfunction

  // Register storage, all bits read/write
  genvar gi;
  generate
    for (gi = 0; gi < pgt_pkg::NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          mask_regs[gi] <= reset_value(gi);  // see R07
        end else if (clk_en_i && reg_wr_i && decode_addr(reg_addr_i) == (3'h4 + 3'(gi))) begin
          mask_regs[gi] <= reg_wdata_i;  // see R07
        end
      end
    end
  endgenerate

  // Read data valid the cycle after the strobe only
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      if (reg_rd_i && decode_addr(reg_addr_i) != 3'h0) begin
        reg_rdata_o <= mask_regs[2'(decode_addr(reg_addr_i) - 3'h4)];
      end else begin
        reg_rdata_o <= pgt_pkg::READ_UNMAPPED;
      end
    end
  end

  // Source vector: low byte matches mask A, high byte mask B
  always_comb begin
    src_vec                                      = 16'h0000;
    src_vec[pgt_pkg::BIT_BUCK_SIX:pgt_pkg::BIT_BUCK_ONE] = buck_channel_good_i;  // see R04 see R08
    src_vec[pgt_pkg::BIT_SWITCH_A_ONE]           = switch_a_one_good_i;
    src_vec[pgt_pkg::BIT_LINEAR_REG_A_TWO]       = linear_reg_a_two_good_i;
    src_vec[8 + pgt_pkg::BIT_LINEAR_REG_A_THREE] = linear_reg_a_three_good_i;  // see R03
    src_vec[8 + pgt_pkg::BIT_SWITCH_B_ONE]       = switch_b_one_good_i;
    src_vec[8 + pgt_pkg::BIT_SHARED_SOURCE]      = shared_source_good_i;
    src_vec[8 + pgt_pkg::BIT_TERMINATION]        = termination_regulator_good_i;  // see R02
    src_vec[8 + pgt_pkg::BIT_CTL_ONE]            = control_input_i[0];  // see R01
    src_vec[8 + pgt_pkg::BIT_CTL_TWO]            = control_input_i[1];
    src_vec[8 + pgt_pkg::BIT_CTL_FOUR]           = control_input_i[3];
    src_vec[8 + pgt_pkg::BIT_CTL_FIVE]           = control_input_i[4];
  end

  assign next_good_1_mask = {mask_regs[1], mask_regs[0]};
  assign next_good_4_mask = {mask_regs[3], mask_regs[2]};  // see R05

  pgt_tree u_tree_one (
    .src_good_i (src_vec),
    .mask_i     (next_good_1_mask),
    .good_o     (tree_good_one)
  );

  pgt_tree u_tree_four (
    .src_good_i (src_vec),
    .mask_i     (next_good_4_mask),
    .good_o     (tree_good_four)
  );

  // Registered so the pins do not glitch on source skew
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status_output_one_o  <= 1'b0;
      status_output_four_o <= 1'b0;
    end else if (clk_en_i) begin
      status_output_one_o  <= tree_good_one;  // see R09
      status_output_four_o <= tree_good_four;  // see R09
    end
  end
endmodule

//--- pgt_mask_bank_sva.sv
/* Checker for the mask bank port and the output one tree.
   Assumes a bind to pgt_mask_bank, enable high in reset. */
module pgt_mask_bank_sva (
  // Bank ports
  input logic       clk_i,
  input logic       srst_i,
  input logic       clk_en_i,
  input logic [7:0] reg_addr_i,
  input logic [7:0] reg_wdata_i,
  input logic       reg_wr_i,
  input logic       reg_rd_i,
  input logic [7:0] reg_rdata_o,
  input logic [5:0] buck_channel_good_i,
  input logic       status_output_one_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire hit = reg_addr_i[7:2] == 6'h29;
  logic [7:0] m1a;
  // Shadow of one mask, enough to predict one tree leg
  always_ff @(posedge clk_i)
    if (srst_i)
      m1a <= pgt_pkg::RST_OUT1_MASK_A;
    else if (clk_en_i && reg_wr_i && reg_addr_i == pgt_pkg::ADDR_OUT1_MASK_A)
      m1a <= reg_wdata_i;
  sequence s_wr_rd; clk_en_i && reg_wr_i ##1 clk_en_i && reg_rd_i && hit && $stable(reg_addr_i); endsequence
  a_read_back: assert property (s_wr_rd |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("read back wrong");
  a_idle_zero: assert property (clk_en_i && !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("idle data");
  a_unmapped_zero: assert property (clk_en_i && reg_rd_i && !hit |=> reg_rdata_o == 8'h00)
    else $error("unmapped data");
  a_mask_a_read: assert property (clk_en_i && reg_rd_i && reg_addr_i == pgt_pkg::ADDR_OUT1_MASK_A
    |=> reg_rdata_o == $past(m1a))
    else $error("mask read wrong");
  a_buck_drop: assert property (clk_en_i && !m1a[0] && !buck_channel_good_i[0] |=> !status_output_one_o)
    else $error("fault ignored");
  a_enable_freeze: assert property (!clk_en_i |=> $stable(reg_rdata_o) && $stable(status_output_one_o))
    else $error("moved when off");
  a_reset_clear: assert property (disable iff (1'b0) srst_i && clk_en_i |=> !(|reg_rdata_o || status_output_one_o))
    else $error("reset value");
  a_masked_good: assert property (disable iff (1'b0) srst_i && clk_en_i ##1 !srst_i |=> status_output_one_o)
    else $error("masked not good");
endmodule
bind pgt_mask_bank pgt_mask_bank_sva u_sva (.clk_i, .srst_i, .clk_en_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .buck_channel_good_i, .status_output_one_o);

//--- pgt_mask_bank_tb.sv
/* Bench for the mask bank: register access and tree results.
   Assumes the strobe port timing of the bank. */
module pgt_mask_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; $display("CHECK FAILED %0t bad", $time); end end
  logic clk_i = 0, srst_i = 1, clk_en_i = 1, reg_wr_i = 0, reg_rd_i = 0, status_output_one_o, status_output_four_o;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic [15:0] src = 16'hFFFF;
  int failures = 0, cmp_count = 0, o;
  // Low byte follows mask A, high byte mask B
  pgt_mask_bank DUT (.clk_i, .srst_i, .clk_en_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .buck_channel_good_i(src[5:0]), .switch_a_one_good_i(src[6]), .linear_reg_a_two_good_i(src[7]),
    .linear_reg_a_three_good_i(src[8]), .switch_b_one_good_i(src[9]), .shared_source_good_i(src[10]),
    .termination_regulator_good_i(src[11]), .control_input_i({1'b1, src[15:14], 1'b1, src[13:12]}),
    .status_output_one_o, .status_output_four_o);
  initial forever #5 clk_i = ~clk_i;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i) reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i) reg_rd_i <= 1'b0;
    @(negedge clk_i) `CHK(reg_rdata_o, e)
    @(posedge clk_i);
  endtask
  task automatic st(input logic [1:0] e);
    @(posedge clk_i);
    @(negedge clk_i) `CHK({status_output_one_o, status_output_four_o}, e)
    @(posedge clk_i);
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    st(2'b11);
    rd(8'hA8, 8'h00);
    rd(pgt_pkg::ADDR_OUT1_MASK_A, pgt_pkg::RST_OUT1_MASK_A);
    rd(pgt_pkg::ADDR_OUT1_MASK_B, pgt_pkg::RST_OUT1_MASK_B);
    rd(pgt_pkg::ADDR_OUT4_MASK_A, pgt_pkg::RST_OUT4_MASK_A);
    rd(pgt_pkg::ADDR_OUT4_MASK_B, pgt_pkg::RST_OUT4_MASK_B);
    // One source bad, only its own bit unmasked, then masked again
    for (o = 0; o < 32; o++) begin
      src <= ~(16'h1 << o % 16);
      wr(8'hA4 + 8'(o / 8), ~(8'h1 << o % 8));
      rd(8'hA4 + 8'(o / 8), ~(8'h1 << o % 8));
      st({o > 15, o < 16});
      wr(8'hA4 + 8'(o / 8), 8'hFF);
      src <= 16'hFFFF;
      st(2'b11);
    end
    src <= 16'hFFFE;
    wr(8'hA4, 8'hFE);
    clk_en_i <= 1'b0;
    st(2'b11);
    // Write while frozen must not land
    wr(pgt_pkg::ADDR_OUT1_MASK_B, 8'h00);
    clk_en_i <= 1'b1;
    st(2'b01);
    rd(pgt_pkg::ADDR_OUT1_MASK_B, pgt_pkg::RST_OUT1_MASK_B);
    tally_and_finish;
  end
endmodule

//--- pgt_pkg.sv
/*
  Package for the power-good tree mask bank: register offsets, field
  positions and reset values shared by the bank, its checker and its bench.
  Assumes an 8-bit register port addressed by byte offset.
*/
package pgt_pkg;
  localparam logic [7:0] ADDR_OUT1_MASK_A = 8'hA4;
  localparam logic [7:0] ADDR_OUT1_MASK_B = 8'hA5;
  localparam logic [7:0] ADDR_OUT4_MASK_A = 8'hA6;
  localparam logic [7:0] ADDR_OUT4_MASK_B = 8'hA7;

  localparam int NUM_REGS = 4;
  localparam int SRC_W    = 16;

  // Mask register A field positions
  localparam int BIT_LINEAR_REG_A_TWO  = 7;
  localparam int BIT_SWITCH_A_ONE      = 6;
  localparam int BIT_BUCK_SIX          = 5;
  localparam int BIT_BUCK_ONE          = 0;
  // Mask register B field positions
  localparam int BIT_CTL_FIVE          = 7;
  localparam int BIT_CTL_FOUR          = 6;
  localparam int BIT_CTL_TWO           = 5;
  localparam int BIT_CTL_ONE           = 4;
  localparam int BIT_TERMINATION       = 3;
  localparam int BIT_SHARED_SOURCE     = 2;
  localparam int BIT_SWITCH_B_ONE      = 1;
  localparam int BIT_LINEAR_REG_A_THREE = 0;

  // Factory values vary by variant; all-masked is a neutral default
  localparam logic [7:0] RST_OUT1_MASK_A = 8'hFF;
  localparam logic [7:0] RST_OUT1_MASK_B = 8'hFF;
  localparam logic [7:0] RST_OUT4_MASK_A = 8'hFF;
  localparam logic [7:0] RST_OUT4_MASK_B = 8'hFF;

  localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage

//--- pgt_tree.sv
/*
  One power-good tree: ANDs every source whose mask bit is clear.
  Assumes the sources are synchronous good-high levels.
*/
module pgt_tree (
  // Sources and masks
  input  wire logic [15:0] src_good_i,
  input  wire logic [15:0] mask_i,
  // Result
  output logic             good_o
);
  // Masked bits forced good so they cannot pull the tree low
  assign good_o = &(src_good_i | mask_i);  // see R06 see R09
endmodule
